// file: rtl/psm_ctrl.v
// Purpose: Power-save mode controller: halt, software stop, hardware stop
// Assumes: All inputs synchronous to clk_i; one clock domain
// Notes:   CPU clock and clock generator are controlled by gate outputs
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "psm_map.vh"

module psm_ctrl #(
   parameter NMI_N  = 3,                    // Non-maskable request inputs
   parameter PRIO_W = 4                     // Priority level width
) (
   input  wire                   clk_i,               // System bus clock
   input  wire                   rst_i,               // Sync reset, active high
   input  wire [`PSM_ADDR_W-1:0] wb_adr_i,            // Wishbone byte address
   input  wire [31:0]            wb_dat_i,            // Wishbone write data
   input  wire [3:0]             wb_sel_i,            // Wishbone byte selects
   input  wire                   wb_we_i,             // Wishbone write
   input  wire                   wb_cyc_i,            // Wishbone cycle
   input  wire                   wb_stb_i,            // Wishbone strobe
   output reg  [31:0]            wb_dat_o,            // Wishbone read data
   output reg                    wb_ack_o,            // Wishbone acknowledge
   input  wire                   halt_exec_i,         // CPU executes halt, pulse
   input  wire                   hw_stop_in_n_i,      // Hardware stop pin, low active
   input  wire                   bus_lock_out_i,      // Bus lock from CPU bus unit
   input  wire [NMI_N-1:0]       nmi_req_i,           // Non-maskable requests
   input  wire                   int_req_i,           // Unmasked maskable request
   input  wire [PRIO_W-1:0]      int_prio_i,          // Maskable request priority
   input  wire [PRIO_W-1:0]      nmi_prio_i,          // NMI request priority
   output reg                    cpu_clk_en_o,        // CPU clock enable
   output reg                    periph_clk_en_o,     // Peripheral clock enable
   output reg                    sw_clock_stop_req_o, // Software stop to clock circuit
   output reg                    hw_clock_stop_req_o, // Hardware stop to clock circuit
   output reg                    wake_ack_o,          // Wake request acknowledged, pulse
   output reg                    wake_pend_o,         // Wake request left pending, pulse
   output reg                    wake_next_o          // Continue with next instruction
);

   // ********************************************************************
   // Mode states
   // ********************************************************************
   localparam [4:0] ST_RUN   = 5'h01;
   localparam [4:0] ST_HALT  = 5'h02;
   localparam [4:0] ST_SSTOP = 5'h04;
   localparam [4:0] ST_HSTOP = 5'h08;
   localparam [4:0] ST_LSTOP = 5'h10;  // Pin low under bus lock: CPU only

   reg [4:0]        state_q;
   reg [4:0]        state_d;
   reg [4:0]        ret_q;             // Mode to resume after hardware stop
   reg [7:0]        ctrl_q;            // power_save_ctrl
   reg              armed_q;           // Protection key written
   reg [15:0]       ctx_q;             // CPU context written by the core
   reg              stop_in_q;         // Sampled stop pin, low active
   reg              stop_prev_q;
   reg [NMI_N-1:0]  nmi_q;
   reg              int_q;
   reg [PRIO_W-1:0] int_prio_q;
   reg [PRIO_W-1:0] nmi_prio_q;
   reg              last_ack_q;
   reg              last_pend_q;

   // ********************************************************************
   // Input sampling
   // ********************************************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         stop_in_q   <= 1'b1;
         stop_prev_q <= 1'b1;
         nmi_q       <= {NMI_N{1'b0}};
         int_q       <= 1'b0;
         int_prio_q  <= {PRIO_W{1'b0}};
         nmi_prio_q  <= {PRIO_W{1'b0}};
      end else begin
         stop_in_q   <= hw_stop_in_n_i;
         stop_prev_q <= stop_in_q;
         nmi_q       <= nmi_req_i;
         int_q       <= int_req_i;
         int_prio_q  <= int_prio_i;
         nmi_prio_q  <= nmi_prio_i;
      end
   end

   // ********************************************************************
   // Wake decode
   // ********************************************************************
   wire             ctx_id     = ctx_q[`PSM_CTX_ID];
   wire             ctx_in_int = ctx_q[`PSM_CTX_IN_INT];
   wire             ctx_in_nmi = ctx_q[`PSM_CTX_IN_NMI];
   wire [PRIO_W-1:0] ctx_prio  = ctx_q[`PSM_CTX_PRIO_LO +: PRIO_W];
   wire [NMI_N-1:0] nmi_mask   = ctrl_q[`PSM_BIT_NMI_MASK_LO +: NMI_N];
   wire             int_mask   = ctrl_q[`PSM_BIT_INT_MASK];
   wire             in_sstop   = (state_q == ST_SSTOP);

   // Masks only filter in software stop; masked events are simply dropped
   wire nmi_wake = in_sstop ? |(nmi_q & ~nmi_mask) : |nmi_q;
   wire int_wake = in_sstop ? (int_q & ~int_mask) : int_q;
   wire any_wake = nmi_wake | int_wake;

   // Lower number means higher priority
   wire nmi_hi = ctx_in_nmi ? (nmi_prio_q < ctx_prio) : 1'b1;
   wire int_hi = (int_prio_q < ctx_prio);
   reg  do_ack;
   always @* begin
      if (nmi_wake) begin
         do_ack = nmi_hi;
      end else if (ctx_in_nmi) begin
         do_ack = 1'b0;
      end else if (ctx_in_int) begin
         do_ack = int_hi & ~ctx_id;
      end else begin
         do_ack = ~ctx_id;
      end
   end

   // ********************************************************************
   // Mode sequencer
   // ********************************************************************
   wire pin_low  = ~stop_in_q;
   wire pin_rise = stop_in_q & ~stop_prev_q;
   wire key_hit  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   wire wr_ctrl  = key_hit & (wb_adr_i == `PSM_OFF_CTRL) & armed_q;
   wire wr_key   = key_hit & (wb_adr_i == `PSM_OFF_PROT_CMD);
   wire stop_set = wr_ctrl & wb_dat_i[`PSM_BIT_STOP];

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (pin_low)
               state_d = bus_lock_out_i ? ST_LSTOP : ST_HSTOP;
            else if (stop_set)
               state_d = ST_SSTOP;
            else if (halt_exec_i)
               state_d = ST_HALT;
         end
         ST_HALT: begin
            if (pin_low)
               state_d = bus_lock_out_i ? ST_LSTOP : ST_HSTOP;
            else if (any_wake)
               state_d = ST_RUN;
         end
         ST_SSTOP: begin
            if (pin_low)
               state_d = bus_lock_out_i ? ST_LSTOP : ST_HSTOP;
            else if (any_wake)
               state_d = ST_RUN;
         end
         ST_HSTOP, ST_LSTOP: begin
            if (pin_rise)
               state_d = ret_q;
         end
         default: state_d = ST_RUN;
      endcase
   end

   wire wake_evt = (state_q == ST_HALT || in_sstop) && !pin_low && any_wake;

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q         <= ST_RUN;        // Reset exit behaves as normal reset
         ret_q           <= ST_RUN;
         ctrl_q          <= `PSM_CTRL_RESET;
         armed_q         <= 1'b0;
         ctx_q           <= 16'h0000;
         cpu_clk_en_o    <= 1'b1;
         periph_clk_en_o <= 1'b1;
         sw_clock_stop_req_o <= 1'b0;
         hw_clock_stop_req_o <= 1'b0;
         wake_ack_o      <= 1'b0;
         wake_pend_o     <= 1'b0;
         wake_next_o     <= 1'b0;
         last_ack_q      <= 1'b0;
         last_pend_q     <= 1'b0;
      end else begin
         state_q <= state_d;
         if ((state_q == ST_HALT || state_q == ST_RUN) &&
             (state_d == ST_HSTOP || state_d == ST_LSTOP))
            ret_q <= state_q;
         else if (in_sstop && (state_d == ST_HSTOP || state_d == ST_LSTOP))
            ret_q <= ST_RUN;
         // Protection key is consumed by any write with wb_sel_i[0] set following it
         if (wr_key)
            armed_q <= 1'b1;
         else if (key_hit)
            armed_q <= 1'b0;
         if (wr_ctrl)
            ctrl_q <= wb_dat_i[7:0] & `PSM_CTRL_WMASK;
         else if (in_sstop && state_d != ST_SSTOP)
            ctrl_q[`PSM_BIT_STOP] <= 1'b0;
         if (key_hit && wb_adr_i == `PSM_OFF_CPU_CTX)
            ctx_q <= wb_dat_i[15:0];
         // Clock gating follows next mode; state is frozen, not lost
         cpu_clk_en_o    <= (state_d == ST_RUN);
         periph_clk_en_o <= (state_d == ST_RUN) || (state_d == ST_HALT) ||
                            (state_d == ST_LSTOP);
         sw_clock_stop_req_o <= (state_d == ST_SSTOP);
         hw_clock_stop_req_o <= (state_d == ST_HSTOP);
         wake_ack_o  <= wake_evt & do_ack;
         wake_pend_o <= wake_evt & ~do_ack;
         wake_next_o <= wake_evt & ~do_ack;
         if (wake_evt) begin
            last_ack_q  <= do_ack;
            last_pend_q <= ~do_ack;
         end
      end
   end

   // ********************************************************************
   // Wishbone slave: one wait-free cycle, unmapped reads zero
   // ********************************************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
               `PSM_OFF_CTRL:    wb_dat_o <= {24'h000000, ctrl_q};
               `PSM_OFF_STATUS:  wb_dat_o <= {24'h000000, bus_lock_out_i,
                                              last_ack_q, last_pend_q, state_q};
               `PSM_OFF_CPU_CTX: wb_dat_o <= {16'h0000, ctx_q};
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // psm_ctrl

// file: rtl/psm_map.vh
// Purpose: Constants for the power-save mode controller
// Assumes: Registers sit on classic Wishbone, one 32-bit word each
// Notes:   Offsets are byte addresses
`ifndef PSM_MAP_VH
`define PSM_MAP_VH

// ********************************************************************
// Register offsets
// ********************************************************************
`define PSM_ADDR_W          8
`define PSM_OFF_CTRL        8'h00
`define PSM_OFF_PROT_CMD    8'h04
`define PSM_OFF_STATUS      8'h08
`define PSM_OFF_CPU_CTX     8'h0c

// ********************************************************************
// Control register fields
// ********************************************************************
`define PSM_BIT_STOP        1
`define PSM_BIT_INT_MASK    4
`define PSM_BIT_NMI_MASK_LO 5
`define PSM_BIT_NMI_MASK_HI 7
`define PSM_CTRL_WMASK      8'hf2
`define PSM_CTRL_RESET      8'h00

// ********************************************************************
// Status register fields
// ********************************************************************
`define PSM_STAT_MODE_LO    0
`define PSM_STAT_MODE_HI    4
`define PSM_STAT_PEND       5
`define PSM_STAT_ACK        6
`define PSM_STAT_LOCKED     7

// ********************************************************************
// CPU context register fields
// ********************************************************************
`define PSM_CTX_ID          0
`define PSM_CTX_IN_INT      1
`define PSM_CTX_IN_NMI      2
`define PSM_CTX_PRIO_LO     8
`define PSM_CTX_PRIO_HI     11

`endif

// file: tb/psm_ctrl_monitor.sv
// Purpose: Port checker for the power-save mode controller
// Assumes: One clock, synchronous reset, inputs sampled one cycle before use
// Notes:   Mode waits allow up to three edges for the sampling stage
`timescale 1ns/1ps
module psm_ctrl_monitor #(
   parameter NMI_N = 3                        // Non-maskable request inputs
) (
   input wire             clk_i,               // Clock
   input wire             rst_i,               // Reset
   input wire             halt_exec_i,         // Halt pulse
   input wire             hw_stop_in_n_i,      // Stop pin
   input wire             bus_lock_out_i,      // Bus lock
   input wire [NMI_N-1:0] nmi_req_i,           // NMI requests
   input wire             int_req_i,           // INT request
   input wire             cpu_clk_en_o,        // CPU clock enable
   input wire             periph_clk_en_o,     // Peripheral clock enable
   input wire             sw_clock_stop_req_o, // Software stop request
   input wire             hw_clock_stop_req_o, // Hardware stop request
   input wire             wake_ack_o,          // Ack pulse
   input wire             wake_pend_o,         // Pend pulse
   input wire             wake_next_o          // Next pulse
);
   // ********************************************************************
   // Properties
   // ********************************************************************
   wire wake = int_req_i | (|nmi_req_i);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_halted; !cpu_clk_en_o && periph_clk_en_o && hw_stop_in_n_i; endsequence
   sequence s_run_quiet; cpu_clk_en_o && hw_stop_in_n_i && !wake; endsequence
   sequence s_lock_fall; bus_lock_out_i ##0 $fell(hw_stop_in_n_i); endsequence
   property p_halt_gate; s_run_quiet ##0 $rose(halt_exec_i) |-> ##[1:3] s_halted; endproperty
   property p_sstop_clk; sw_clock_stop_req_o |-> !cpu_clk_en_o && !periph_clk_en_o; endproperty
   property p_hstop_clk; hw_clock_stop_req_o |-> !cpu_clk_en_o && !periph_clk_en_o; endproperty
   property p_pin_enter;
      $fell(hw_stop_in_n_i) && !bus_lock_out_i |-> ##[1:3] hw_clock_stop_req_o;
   endproperty
   property p_lock_stop;
      s_lock_fall |-> ##[1:3] (!cpu_clk_en_o && periph_clk_en_o && !hw_clock_stop_req_o);
   endproperty
   property p_pin_exit;
      $rose(hw_stop_in_n_i) && hw_clock_stop_req_o |-> ##[1:3] !hw_clock_stop_req_o;
   endproperty
   property p_halt_wake; s_halted ##0 $rose(wake) |-> ##[1:3] cpu_clk_en_o; endproperty
   property p_pulses; wake_next_o == wake_pend_o && !(wake_ack_o && wake_pend_o); endproperty
   a_halt_gate: assert property (p_halt_gate) else $error("halt gating wrong");
   a_sstop_clk: assert property (p_sstop_clk) else $error("sw stop clocks");
   a_hstop_clk: assert property (p_hstop_clk) else $error("hw stop clocks");
   a_pin_enter: assert property (p_pin_enter) else $error("no hw stop");
   a_lock_stop: assert property (p_lock_stop) else $error("locked stop wrong");
   a_pin_exit: assert property (p_pin_exit) else $error("hw stop stuck");
   a_halt_wake: assert property (p_halt_wake) else $error("halt not ended");
   a_pulses: assert property (p_pulses) else $error("wake pulses clash");
endmodule // psm_ctrl_monitor

// file: tb/psm_far_model.sv
// Purpose: Far side: stop pin source, bus lock and halt issue
// Assumes: Driven from the bench, all changes on the rising edge
// Notes:   Gating of the pin by the lock can be switched off
`timescale 1ns/1ps
module psm_far_model (
   input  wire clk_i,          // Clock
   input  wire stop_i,         // Stop wanted
   input  wire lock_i,         // Lock wanted
   input  wire gate_i,         // Gate pin with lock
   input  wire halt_i,         // Halt wanted
   output reg  hw_stop_in_n_o, // Stop pin, low active
   output reg  bus_lock_o,     // Bus lock
   output reg  halt_o          // Halt pulse
);
   reg [2:0] gap_q = 3'h0;
   initial begin
      hw_stop_in_n_o = 1'b1;
      bus_lock_o = 1'b0;
      halt_o = 1'b0;
   end
   always @(posedge clk_i) begin
      bus_lock_o <= lock_i;
      hw_stop_in_n_o <= !(stop_i && !(gate_i && lock_i));
      // Six idle cycles stand in for the nops after a halt
      halt_o <= halt_i && gap_q == 3'h0 && !halt_o;
      gap_q <= halt_o ? 3'h5 : (gap_q != 3'h0 ? gap_q - 3'h1 : 3'h0);
   end
endmodule // psm_far_model

// file: tb/testbench.sv
// Purpose: Self-checking bench for the power-save mode controller
// Assumes: Wishbone classic master, 50 ns clock
// Notes:   Mode outputs are checked well after their inputs settle
`timescale 1ns/1ps
`include "psm_map.vh"
module testbench;
   typedef struct packed {logic [7:0] ctrl; logic [2:0] nmi; logic irq; logic wake;} psm_row_t;
   reg clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   reg [7:0] wb_adr_i = 8'h00;
   reg [31:0] wb_dat_i = 32'h0;
   reg [2:0] nmi_req_i = 3'h0;
   reg int_req_i = 1'b0, stop = 1'b0, lock = 1'b0, gate = 1'b0, halt = 1'b0;
   reg [3:0] int_prio_i = 4'h0, nmi_prio_i = 4'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, hstop_n, blk, hx, cpu, per, sws, hws, ack, pend, nxt;
   integer num_errors = 0, comparisons = 0, i, n;
   reg [31:0] r;
   psm_row_t rows [0:6] = '{'{8'h02, 3'h0, 1'b1, 1'b1}, '{8'h12, 3'h0, 1'b1, 1'b0},
      '{8'h22, 3'h1, 1'b0, 1'b0}, '{8'h22, 3'h2, 1'b0, 1'b1}, '{8'h42, 3'h2, 1'b0, 1'b0},
      '{8'h82, 3'h4, 1'b0, 1'b0}, '{8'he2, 3'h1, 1'b1, 1'b1}};
   psm_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(4'h1), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .halt_exec_i(hx), .hw_stop_in_n_i(hstop_n),
      .bus_lock_out_i(blk), .nmi_req_i(nmi_req_i), .int_req_i(int_req_i),
      .int_prio_i(int_prio_i), .nmi_prio_i(nmi_prio_i), .cpu_clk_en_o(cpu),
      .periph_clk_en_o(per), .sw_clock_stop_req_o(sws), .hw_clock_stop_req_o(hws),
      .wake_ack_o(ack), .wake_pend_o(pend), .wake_next_o(nxt));
   psm_far_model far (.clk_i(clk_i), .stop_i(stop), .lock_i(lock), .gate_i(gate),
      .halt_i(halt), .hw_stop_in_n_o(hstop_n), .bus_lock_o(blk), .halt_o(hx));
   // ********************************************************************
   // Tasks
   // ********************************************************************
   task tick(input integer c); repeat (c) @(posedge clk_i); endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wb(input [7:0] a, input [31:0] d, input w);
      begin
         wb_adr_i <= a; wb_dat_i <= d; wb_we_i <= w; wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1;
         n = 0;
         // Ack and data are sampled at the edge that sees ack high, then released
         do begin @(posedge clk_i); n = n + 1; end while (wb_ack_o !== 1'b1 && n < 20);
         if (n >= 20) num_errors = num_errors + 1;
         r = wb_dat_o;
         wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task rd(input [7:0] a, input [31:0] e); begin wb(a, 32'h0, 1'b0); chk(r, e); end endtask
   task report_and_stop;
      begin
         $display("errors %0d comparisons %0d", num_errors, comparisons);
         if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   integer n_ack = 0, n_nxt = 0;
   // Pulse counters so one-cycle wake outputs are not missed between checks
   always @(posedge clk_i) begin n_ack <= n_ack + ack; n_nxt <= n_nxt + nxt; end
   initial forever #25 clk_i = !clk_i;
   initial begin tick(6000); num_errors = num_errors + 1; report_and_stop; end
   // ********************************************************************
   // Sequence
   // ********************************************************************
   initial begin
      tick(4); rst_i <= 1'b0; tick(1);
      for (i = 0; i < 7; i = i + 1) begin
         wb(`PSM_OFF_PROT_CMD, {24'h0, rows[i].ctrl}, 1'b1);
         wb(`PSM_OFF_CTRL, {24'h0, rows[i].ctrl}, 1'b1); tick(2);
         chk(sws, 1'b1);
         nmi_req_i <= rows[i].nmi; int_req_i <= rows[i].irq; tick(4);
         chk(sws, !rows[i].wake);
         nmi_req_i <= 3'h0; int_req_i <= 1'b0;
         if (!rows[i].wake) begin stop <= 1'b1; tick(5); chk(hws, 1'b1); stop <= 1'b0; tick(5); end
         chk(cpu, 1'b1);
         rd(`PSM_OFF_CTRL, {24'h0, rows[i].ctrl & 8'hf0});
      end
      wb(`PSM_OFF_CTRL, 32'h2, 1'b1); wb(`PSM_OFF_PROT_CMD, 32'h2, 1'b1);
      wb(`PSM_OFF_STATUS, 32'h0, 1'b1); wb(`PSM_OFF_CTRL, 32'h2, 1'b1); tick(2);
      chk(sws, 1'b0);
      wb(`PSM_OFF_CPU_CTX, 32'h502, 1'b1); halt <= 1'b1; tick(1); halt <= 1'b0; tick(4);
      chk({cpu, per}, 2'b01);
      int_prio_i <= 4'h9; int_req_i <= 1'b1; tick(4); int_req_i <= 1'b0;
      rd(`PSM_OFF_STATUS, 32'h21);
      halt <= 1'b1; tick(1); halt <= 1'b0; tick(4);
      nmi_prio_i <= 4'h1; nmi_req_i <= 3'h4; tick(4); nmi_req_i <= 3'h0;
      rd(`PSM_OFF_STATUS, 32'h41);
      halt <= 1'b1; tick(1); halt <= 1'b0; tick(4); stop <= 1'b1; tick(5);
      chk(hws, 1'b1); stop <= 1'b0; tick(5);
      chk({cpu, per, hws}, 3'b010);
      int_prio_i <= 4'h0; int_req_i <= 1'b1; tick(4); int_req_i <= 1'b0;
      chk(cpu, 1'b1);
      lock <= 1'b1; stop <= 1'b1; tick(5);
      chk({cpu, per, hws}, 3'b010); stop <= 1'b0; tick(5);
      gate <= 1'b1; stop <= 1'b1; tick(5);
      chk(cpu, 1'b1); stop <= 1'b0; lock <= 1'b0; gate <= 1'b0;
      chk(n_ack, 32'd5);
      chk(n_nxt, 32'd1);
      wb(`PSM_OFF_PROT_CMD, 32'h2, 1'b1); wb(`PSM_OFF_CTRL, 32'h2, 1'b1); tick(2);
      rst_i <= 1'b1; tick(2); rst_i <= 1'b0; tick(1);
      chk({cpu, per, sws, hws}, 4'b1100);
      rd(`PSM_OFF_CTRL, 32'h0);
      rd(8'h10, 32'h0);
      report_and_stop;
   end
endmodule // testbench
bind psm_ctrl psm_ctrl_monitor #(.NMI_N(NMI_N)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .halt_exec_i(halt_exec_i), .hw_stop_in_n_i(hw_stop_in_n_i),
   .bus_lock_out_i(bus_lock_out_i), .nmi_req_i(nmi_req_i), .int_req_i(int_req_i),
   .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
   .sw_clock_stop_req_o(sw_clock_stop_req_o), .hw_clock_stop_req_o(hw_clock_stop_req_o),
   .wake_ack_o(wake_ack_o), .wake_pend_o(wake_pend_o), .wake_next_o(wake_next_o));
